// File: hw/hbridge_cfg.svh
// Purpose: timing constants and encodings for the H-bridge motor control
// Assumes: ref_clk at 100 MHz
// Notes:   times kept in their own unit, cycle counts derived from them
`ifndef HBRIDGE_CFG_SVH
`define HBRIDGE_CFG_SVH

`define CLK_MHZ            100
// Times in ns
`define SLEEP_ENTRY_NS     1200000
`define WAKE_HOLD_NS       5000
`define WAKE_DELAY_NS      45000
`define OFF_TIME_NS        30000
`define BLANK_NS           3200
`define DEAD_NS            200
`define OC_FILTER_NS       2500
`define RETRY_NS           4000000
// Cycle counts; least times round up, none below one
`define NS2CYC_UP(t)       (((t) * `CLK_MHZ + 999) / 1000)
`define SLEEP_ENTRY_CYC    `NS2CYC_UP(`SLEEP_ENTRY_NS)
`define WAKE_HOLD_CYC      `NS2CYC_UP(`WAKE_HOLD_NS)
`define WAKE_DELAY_CYC     `NS2CYC_UP(`WAKE_DELAY_NS)
`define OFF_TIME_CYC       `NS2CYC_UP(`OFF_TIME_NS)
`define BLANK_CYC          `NS2CYC_UP(`BLANK_NS)
`define DEAD_CYC           `NS2CYC_UP(`DEAD_NS)
`define OC_FILTER_CYC      `NS2CYC_UP(`OC_FILTER_NS)
`define RETRY_CYC          `NS2CYC_UP(`RETRY_NS)
`define CNT_W              20
`define CNT_ZERO           20'h00000
`define CNT_ONE            20'h00001
`define PWM_W              16
`define PWM_ZERO           16'h0000
`define PWM_ONE            16'h0001

`endif

// File: hw/hbridge_controller.sv
// Purpose: controller end, PWM of the direction inputs
// Assumes: ref_clk at 100 MHz, period of at least 1000 cycles (100 kHz)
// Notes:   off phase of PWM is brake, not coast
`timescale 1ns/1ns
`default_nettype none
`include "hbridge_cfg.svh"
module hbridge_controller (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset,
  // User command
  input  wire hbridge_pkg::drive_mode_t mode,
  input  wire logic [`PWM_W-1:0]        pwmPeriod,
  input  wire logic [`PWM_W-1:0]        pwmDuty,
  // Link
  hbridge_if.controller                 link
);
  logic [`PWM_W-1:0] pwmCount;
  logic              onPhase;
  logic              dirA;
  logic              dirB;

  // ==========================================================
  // PWM period counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pwmCount <= `PWM_ZERO;
    end else if (pwmCount + `PWM_ONE >= pwmPeriod) begin
      pwmCount <= `PWM_ZERO;
    end else begin
      pwmCount <= pwmCount + `PWM_ONE;
    end
  end

  assign onPhase = pwmCount < pwmDuty;

  // ==========================================================
  // One input modulated, other static; off phase brakes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dirA <= 1'b0;
      dirB <= 1'b0;
    end else begin
      case (mode)
        hbridge_pkg::DRIVE_FORWARD: begin
          dirA <= 1'b1;
          dirB <= ~onPhase;
        end
        hbridge_pkg::DRIVE_REVERSE: begin
          dirA <= ~onPhase;
          dirB <= 1'b1;
        end
        hbridge_pkg::DRIVE_BRAKE: begin
          dirA <= 1'b1;
          dirB <= 1'b1;
        end
        default: begin
          dirA <= 1'b0;
          dirB <= 1'b0;
        end
      endcase
    end
  end

  // Inputs may be driven regardless of motor supply
  assign link.directionInputA = dirA;
  assign link.directionInputB = dirB;
endmodule // hbridge_controller
`default_nettype wire

// File: hw/hbridge_device.sv
// Behaviour
// - Both inputs low: all switches off, coast
// - A only forward, B only reverse
// - Both inputs high: brake on low sides
// - Inputs low for sleep delay: sleep
// - Power-up with inputs low: sleep at once
// - Wake hold 5 us, operational 45 us later
// - Current trip: slow decay for off time
// - After off time, follow inputs again
// - Undervoltage forces all switches off
// - Supply recovered: resume without action
// - Overcurrent past filter time: switches off
// - Retry after 4 ms, repeat if persisting
// - Over-temperature off, resume when cleared
// - Controller PWM up to 100 kHz
// - Controller PWM alternates drive and brake
// - Controller modulates one input only
// - Inputs may precede motor supply
//
// Purpose: H-bridge device control logic
// Assumes: ref_clk at 100 MHz; indications synchronous to it
// Notes:   high-side gate on drives output high, low-side drives it low
`timescale 1ns/1ns
`default_nettype none
`include "hbridge_cfg.svh"
module hbridge_device #(
  parameter int unsigned SLEEP_ENTRY_CYCLES = `SLEEP_ENTRY_CYC,
  parameter int unsigned RETRY_CYCLES       = `RETRY_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Analog indications
  input  wire logic supplyUndervoltageLockout,
  input  wire logic thermalCutoff,
  input  wire logic overcurrentDetect,
  input  wire logic regulationTripCurrent,
  // Status
  output logic      sleeping,
  output logic      overcurrentShutdown,
  output logic      highSideA,
  output logic      lowSideA,
  output logic      highSideB,
  output logic      lowSideB,
  // Link
  hbridge_if.device link
);
  hbridge_pkg::bridge_state_t state;
  logic [`CNT_W-1:0] timer;
  logic [`CNT_W-1:0] lowCount;
  logic [`CNT_W-1:0] ocCount;
  logic [`CNT_W-1:0] blankCount;
  logic              powerUp;
  logic              fault;
  logic              anyHigh;
  logic              blanked;
  logic [3:0]        want;
  logic [3:0]        gate;

  // Four gate wants: high A, low A, high B, low B
  function automatic logic [3:0] decode(input logic a, input logic b);
    case ({a, b})
      2'b10:   decode = 4'h9;
      2'b01:   decode = 4'h6;
      2'b11:   decode = 4'h5;
      default: decode = 4'h0;
    endcase
  endfunction

  assign anyHigh = link.directionInputA | link.directionInputB;
  assign fault   = supplyUndervoltageLockout | thermalCutoff;

  // ==========================================================
  // Input low time and power-up flag
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lowCount <= `CNT_ZERO;
    end else if (anyHigh) begin
      lowCount <= `CNT_ZERO;
    end else if (lowCount < SLEEP_ENTRY_CYCLES[`CNT_W-1:0]) begin
      lowCount <= lowCount + `CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      powerUp <= 1'b1;
    end else begin
      powerUp <= 1'b0;
    end
  end

  // ==========================================================
  // Overcurrent filter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ocCount <= `CNT_ZERO;
    end else if (!overcurrentDetect || state != hbridge_pkg::ST_RUN) begin
      ocCount <= `CNT_ZERO;
    end else if (ocCount <= `CNT_W'(`OC_FILTER_CYC)) begin
      ocCount <= ocCount + `CNT_ONE;
    end
  end

  // ==========================================================
  // Main sequence
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= hbridge_pkg::ST_SLEEP;
      timer <= `CNT_ZERO;
    end else begin
      case (state)
        hbridge_pkg::ST_SLEEP: begin
          if (!anyHigh) begin
            timer <= `CNT_ZERO;
          end else if (timer + `CNT_ONE >= `CNT_W'(`WAKE_HOLD_CYC)) begin
            state <= hbridge_pkg::ST_WAKE;
            timer <= `CNT_ZERO;
          end else begin
            timer <= timer + `CNT_ONE;
          end
        end
        hbridge_pkg::ST_WAKE: begin
          if (timer + `CNT_ONE >= `CNT_W'(`WAKE_DELAY_CYC)) begin
            state <= hbridge_pkg::ST_RUN;
            timer <= `CNT_ZERO;
          end else begin
            timer <= timer + `CNT_ONE;
          end
        end
        hbridge_pkg::ST_RUN: begin
          timer <= `CNT_ZERO;
          if (powerUp && !anyHigh) begin
            state <= hbridge_pkg::ST_SLEEP;
          end else if (lowCount >= SLEEP_ENTRY_CYCLES[`CNT_W-1:0]) begin
            state <= hbridge_pkg::ST_SLEEP;
          end else if (ocCount > `CNT_W'(`OC_FILTER_CYC)) begin
            state <= hbridge_pkg::ST_RETRY;
          end else if (regulationTripCurrent && !blanked && !fault) begin
            state <= hbridge_pkg::ST_CHOP;
          end
        end
        hbridge_pkg::ST_CHOP: begin
          if (timer + `CNT_ONE >= `CNT_W'(`OFF_TIME_CYC)) begin
            state <= hbridge_pkg::ST_RUN;
            timer <= `CNT_ZERO;
          end else begin
            timer <= timer + `CNT_ONE;
          end
        end
        hbridge_pkg::ST_RETRY: begin
          if (timer + `CNT_ONE >= RETRY_CYCLES[`CNT_W-1:0]) begin
            state <= hbridge_pkg::ST_RUN;
            timer <= `CNT_ZERO;
          end else begin
            timer <= timer + `CNT_ONE;
          end
        end
        default: begin
          state <= hbridge_pkg::ST_SLEEP;
          timer <= `CNT_ZERO;
        end
      endcase
    end
  end

  // ==========================================================
  // Wanted gates; faults override inputs and resume on their own
  always_comb begin
    want = 4'h0;
    if (fault) begin
      want = 4'h0;
    end else if (state == hbridge_pkg::ST_RUN) begin
      want = decode(link.directionInputA, link.directionInputB);
    end else if (state == hbridge_pkg::ST_CHOP) begin
      want = 4'h5;
    end
  end

  // ==========================================================
  // Dead time and blanking
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_leg
      logic [`CNT_W-1:0] dead;
      logic              hi, lo;
      logic              wHi, wLo;
      assign wHi = want[3 - 2 * g];
      assign wLo = want[2 - 2 * g];
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          dead <= `CNT_ZERO;
          hi   <= 1'b0;
          lo   <= 1'b0;
        end else if ((hi && !wHi) || (lo && !wLo)) begin
          hi   <= hi & wHi;
          lo   <= lo & wLo;
          dead <= `CNT_ZERO;
        end else if (!hi && !lo && (wHi || wLo)) begin
          if (dead + `CNT_ONE >= `CNT_W'(`DEAD_CYC)) begin
            hi <= wHi;
            lo <= wLo;
          end else begin
            dead <= dead + `CNT_ONE;
          end
        end else begin
          dead <= `CNT_ZERO;
        end
      end
      assign gate[3 - 2 * g] = hi;
      assign gate[2 - 2 * g] = lo;
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      blankCount <= `CNT_ZERO;
    end else if (want != gate || state != hbridge_pkg::ST_RUN) begin
      blankCount <= `CNT_ZERO;
    end else if (blankCount < `CNT_W'(`BLANK_CYC)) begin
      blankCount <= blankCount + `CNT_ONE;
    end
  end
  assign blanked = blankCount < `CNT_W'(`BLANK_CYC);

  // ==========================================================
  // Outputs
  assign {highSideA, lowSideA, highSideB, lowSideB} = gate;
  assign link.bridgeOutputA   = gate[3];
  assign link.bridgeOutputAEn = gate[3] | gate[2];
  assign link.bridgeOutputB   = gate[1];
  assign link.bridgeOutputBEn = gate[1] | gate[0];
  assign sleeping             = state == hbridge_pkg::ST_SLEEP;
  assign overcurrentShutdown  = state == hbridge_pkg::ST_RETRY;
endmodule // hbridge_device
`default_nettype wire

// File: hw/hbridge_if.sv
// Purpose: link between controller and H-bridge device
// Assumes: one clock, signals synchronous to it
// Notes:   analog indications are carried as logic levels
`timescale 1ns/1ns
`default_nettype none
interface hbridge_if;
  // Direction inputs
  logic directionInputA;
  logic directionInputB;
  // Bridge outputs, value and enable
  logic bridgeOutputA;
  logic bridgeOutputAEn;
  logic bridgeOutputB;
  logic bridgeOutputBEn;

  modport device (
    input  directionInputA,
    input  directionInputB,
    output bridgeOutputA,
    output bridgeOutputAEn,
    output bridgeOutputB,
    output bridgeOutputBEn
  );
  modport controller (
    output directionInputA,
    output directionInputB,
    input  bridgeOutputA,
    input  bridgeOutputAEn,
    input  bridgeOutputB,
    input  bridgeOutputBEn
  );
endinterface
`default_nettype wire

// File: hw/hbridge_pkg.sv
// Purpose: types for the two ends of the H-bridge link, drive mode for the controller, state for the device
// Assumes: nothing
// Notes:   none
`default_nettype none
package hbridge_pkg;
  typedef enum logic [1:0] {
    DRIVE_COAST,
    DRIVE_FORWARD,
    DRIVE_REVERSE,
    DRIVE_BRAKE
  } drive_mode_t;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_WAKE,
    ST_RUN,
    ST_CHOP,
    ST_RETRY
  } bridge_state_t;
endpackage
`default_nettype wire

// File: verif/hbridge_motor_control_sva.sv
// Purpose: assertions on the H-bridge link
// Assumes: one clock, reset async high
// Notes:   sees the link signals only
`timescale 1ns/1ns
`default_nettype none
`include "hbridge_cfg.svh"
module hbridge_motor_control_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Link
  input wire logic directionInputA,
  input wire logic directionInputB,
  input wire logic bridgeOutputA,
  input wire logic bridgeOutputAEn,
  input wire logic bridgeOutputB,
  input wire logic bridgeOutputBEn
);
  // ==========================================
  // Helper logic
  localparam logic [12:0] WAKE_MIN = 13'(`WAKE_HOLD_CYC + `WAKE_DELAY_CYC);
  localparam logic [12:0] WAKE_MAX = WAKE_MIN + 13'h0064;
  logic [12:0] wakeCnt;
  logic        everEn;
  wire logic   inA = directionInputA;
  wire logic   inB = directionInputB;
  wire logic   hiA = bridgeOutputAEn && bridgeOutputA;
  wire logic   hiB = bridgeOutputBEn && bridgeOutputB;
  wire logic   anyEn = bridgeOutputAEn || bridgeOutputBEn;

  // Consecutive cycles with an input high, saturating
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) wakeCnt <= 13'h0000;
    else if (!(inA || inB)) wakeCnt <= 13'h0000;
    else if (wakeCnt != 13'h1fff) wakeCnt <= wakeCnt + 13'h0001;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) everEn <= 1'b0;
    else everEn <= everEn || anyEn;
  end

  // ==========================================
  // Assertions
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_coast_float: assert property (
    (!inA && !inB) [*8] |-> !anyEn) else $error("coast not floating");
  chk_never_both_hi: assert property (
    !(hiA && hiB)) else $error("both outputs high");
  chk_fwd_dir: assert property (
    (inA && !inB) [*8] |-> !hiB) else $error("forward drives B high");
  chk_rev_dir: assert property (
    (!inA && inB) [*8] |-> !hiA) else $error("reverse drives A high");
  chk_brake_low: assert property (
    (inA && inB) [*8] |-> !hiA && !hiB) else $error("brake not low");
  chk_dead_gap_a: assert property (
    bridgeOutputAEn && $past(bridgeOutputAEn) |-> $stable(bridgeOutputA))
    else $error("leg A switched without gap");
  chk_dead_gap_b: assert property (
    bridgeOutputBEn && $past(bridgeOutputBEn) |-> $stable(bridgeOutputB))
    else $error("leg B switched without gap");
  chk_wake_early: assert property (
    !everEn && anyEn |-> wakeCnt >= WAKE_MIN) else $error("woke early");
  chk_wake_late: assert property (
    !everEn && wakeCnt == WAKE_MAX |-> everEn) else $error("woke late");

  cov_forward: cover property (hiA && bridgeOutputBEn);
  cov_brake: cover property (bridgeOutputAEn && bridgeOutputBEn && !hiA && !hiB);
  cov_reverse: cover property (hiB && bridgeOutputAEn);
endmodule // hbridge_motor_control_sva
`default_nettype wire

// File: verif/tb_hbridge_motor_control.sv
// Purpose: self-checking bench for both ends of the H-bridge link
// Assumes: 100 MHz clock, short sleep and retry counts
// Notes:   outs packs {AEn, A, BEn, B}
`timescale 1ns/1ns
`default_nettype none
module tb_hbridge_motor_control;
  localparam logic [3:0] FWD = 4'he, REV = 4'hb, BRK = 4'ha, OFF = 4'h0;
  logic                     ref_clk, reset, uv, hot, ocDet, trip;
  logic                     sleeping, ocOff;
  logic [15:0]              period, duty;
  hbridge_pkg::drive_mode_t mode;
  int                       nFail = 0, testsRun = 0, n, nA, nB;

  hbridge_if link ();
  wire logic [3:0] outs = {link.bridgeOutputAEn, link.bridgeOutputA,
                           link.bridgeOutputBEn, link.bridgeOutputB};

  hbridge_controller i_hbridge_controller (.ref_clk(ref_clk), .reset(reset),
    .mode(mode), .pwmPeriod(period), .pwmDuty(duty), .link(link));
  hbridge_device #(.SLEEP_ENTRY_CYCLES(200), .RETRY_CYCLES(300))
  i_hbridge_device (.ref_clk(ref_clk), .reset(reset),
    .supplyUndervoltageLockout(uv), .thermalCutoff(hot),
    .overcurrentDetect(ocDet), .regulationTripCurrent(trip),
    .sleeping(sleeping), .overcurrentShutdown(ocOff), .highSideA(),
    .lowSideA(), .highSideB(), .lowSideB(), .link(link));
  hbridge_motor_control_sva i_hbridge_motor_control_sva (.ref_clk(ref_clk),
    .reset(reset), .directionInputA(link.directionInputA),
    .directionInputB(link.directionInputB),
    .bridgeOutputA(link.bridgeOutputA),
    .bridgeOutputAEn(link.bridgeOutputAEn),
    .bridgeOutputB(link.bridgeOutputB),
    .bridgeOutputBEn(link.bridgeOutputBEn));

  // ==========================================
  // Tasks
  task automatic results();
    if (nFail == 0 && testsRun > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic waitEn();
    n = 0;
    while (link.bridgeOutputAEn !== 1'b1 && n < 6000) begin
      cyc(1);
      n++;
    end
    if (n == 6000) begin
      nFail++;
      results();
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Main sequence
  initial begin
    {reset, uv, hot, ocDet, trip} = 5'h10;
    mode = hbridge_pkg::DRIVE_COAST;
    period = 16'h03e8;
    duty = 16'h03e8;
    cyc(5);
    reset = 1'b0;
    cyc(3);
    check({3'h0, sleeping}, 4'h1);
    mode = hbridge_pkg::DRIVE_FORWARD;
    waitEn();
    check({3'h0, n >= 5000}, 4'h1);
    cyc(10);
    check(outs, FWD);
    mode = hbridge_pkg::DRIVE_REVERSE;
    cyc(100);
    check(outs, REV);
    mode = hbridge_pkg::DRIVE_BRAKE;
    cyc(100);
    check(outs, BRK);
    mode = hbridge_pkg::DRIVE_FORWARD;
    cyc(400);
    trip = 1'b1;
    cyc(1);
    trip = 1'b0;
    cyc(100);
    check(outs, BRK);
    cyc(3100);
    check(outs, FWD);
    trip = 1'b1;
    cyc(1);
    trip = 1'b0;
    cyc(50);
    check(outs, FWD);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) uv = 1'b1;
      else hot = 1'b1;
      cyc(3);
      check(outs, OFF);
      uv = 1'b0;
      hot = 1'b0;
      cyc(100);
      check(outs, FWD);
    end
    ocDet = 1'b1;
    cyc(240);
    check(outs, FWD);
    cyc(20);
    check(outs, OFF);
    check({3'h0, ocOff}, 4'h1);
    cyc(200);
    check(outs, OFF);
    cyc(200);
    check(outs, FWD);
    cyc(200);
    check(outs, OFF);
    check({3'h0, ocOff}, 4'h1);
    ocDet = 1'b0;
    cyc(300);
    check(outs, FWD);
    mode = hbridge_pkg::DRIVE_COAST;
    cyc(50);
    check(outs, OFF);
    cyc(50);
    check({3'h0, sleeping}, 4'h0);
    cyc(200);
    check({3'h0, sleeping}, 4'h1);
    duty = 16'h01f4;
    mode = hbridge_pkg::DRIVE_FORWARD;
    waitEn();
    {nA, nB} = 0;
    repeat (2000) begin
      cyc(1);
      nA += int'(link.directionInputA !== 1'b1);
      nB += int'(link.directionInputB === 1'b1);
    end
    check({3'h0, nA == 0}, 4'h1);
    check({3'h0, nB == 1000}, 4'h1);
    results();
  end
endmodule // tb_hbridge_motor_control
`default_nettype wire
